// file: rtl/dou_defs.svh
// Offset, scaling and timing constants for the demodulator offset unit
`ifndef DOU_DEFS_SVH
`define DOU_DEFS_SVH

`define DOU_DW 16
`define DOU_FULL_SCALE 16'sh2710
`define DOU_SAT_LIMIT 16'sh2AF8
`define DOU_LOG_FS_DBM 200
`define DOU_DBM_UNITS_PER_DB (10000 / `DOU_LOG_FS_DBM)
`define DOU_DB_PER_OCTAVE_X16 20'sh01813
`define DOU_LOG2_FS_X16 12'h0D5
`define DOU_DBM_AT_FS 16'sh0000
`define DOU_ANGLE_W 16
`define DOU_CORDIC_ITER 4'hE
`define DOU_CORDIC_GAIN_INV 20'sh04DBA
`define DOU_CORDIC_W 20

`endif

// file: rtl/dou_pkg.sv
// Types shared by the demodulator offset unit
package dou_pkg;
   typedef enum logic [2:0]
   {
      QTY_X = 3'b000,
      QTY_R_VOLT = 3'b001,
      QTY_LOG_POWER_MAGNITUDE = 3'b010,
      QTY_NOISE = 3'b011,
      QTY_AUX1 = 3'b100
   } dou_qty_t;

   typedef enum logic [1:0]
   {
      TGT_X = 2'b00,
      TGT_Y = 2'b01,
      TGT_R_VOLT = 2'b10,
      TGT_LOG_POWER_MAGNITUDE = 2'b11
   } dou_tgt_t;

   typedef enum logic [1:0]
   {
      CST_IDLE = 2'b00,
      CST_RUN = 2'b01,
      CST_SCALE = 2'b10
   } dou_cst_t;
endpackage

// file: rtl/dou_rotator.sv
// Shift-add vector rotator for the X/Y offset pair
`timescale 1ns/1ns
`include "dou_defs.svh"
module dou_rotator
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_start,
   input wire logic signed [`DOU_DW-1:0] i_x,
   input wire logic signed [`DOU_DW-1:0] i_y,
   input wire logic [`DOU_ANGLE_W-1:0] i_angle,
   output logic o_busy,
   output logic o_done,
   output logic signed [`DOU_DW-1:0] o_x,
   output logic signed [`DOU_DW-1:0] o_y
);
   localparam int CW = `DOU_CORDIC_W;
   dou_pkg::dou_cst_t state_q;
   logic signed [CW-1:0] x_q, y_q;
   logic signed [`DOU_ANGLE_W-1:0] z_q;
   logic [3:0] it_q;
   logic [4:0] busy_run_q;
   logic signed [CW-1:0] xs, ys;
   logic signed [2*CW-1:0] px, py;

   function automatic logic signed [`DOU_ANGLE_W-1:0] atan_step(input logic [3:0] i);
      case (i)
         4'h0: atan_step = 16'sh2000;
         4'h1: atan_step = 16'sh12E4;
         4'h2: atan_step = 16'sh09FB;
         4'h3: atan_step = 16'sh0511;
         4'h4: atan_step = 16'sh028B;
         4'h5: atan_step = 16'sh0146;
         4'h6: atan_step = 16'sh00A3;
         4'h7: atan_step = 16'sh0051;
         4'h8: atan_step = 16'sh0029;
         4'h9: atan_step = 16'sh0014;
         4'hA: atan_step = 16'sh000A;
         4'hB: atan_step = 16'sh0005;
         4'hC: atan_step = 16'sh0003;
         default: atan_step = 16'sh0001;
      endcase
   endfunction

   assign xs = x_q >>> it_q;
   assign ys = y_q >>> it_q;
   assign px = x_q * `DOU_CORDIC_GAIN_INV;
   assign py = y_q * `DOU_CORDIC_GAIN_INV;

   // Sine/cosine rotation, finished within a fixed 16 cycles
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q <= dou_pkg::CST_IDLE;
         x_q <= '0;
         y_q <= '0;
         z_q <= '0;
         it_q <= 4'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_x <= '0;
         o_y <= '0;
      end
      else
      begin
         o_done <= 1'b0;
         case (state_q)
            dou_pkg::CST_IDLE:
            begin
               if (i_start)
               begin
                  // Fold the angle into +-90 degrees
                  if (i_angle[15] ^ i_angle[14])
                  begin
                     x_q <= -CW'(i_x);
                     y_q <= -CW'(i_y);
                     z_q <= $signed(i_angle ^ 16'h8000);
                  end
                  else
                  begin
                     x_q <= CW'(i_x);
                     y_q <= CW'(i_y);
                     z_q <= $signed(i_angle);
                  end
                  it_q <= 4'h0;
                  o_busy <= 1'b1;
                  state_q <= dou_pkg::CST_RUN;
               end
            end
            dou_pkg::CST_RUN:
            begin
               if (!z_q[15])
               begin
                  x_q <= x_q - ys;
                  y_q <= y_q + xs;
                  z_q <= z_q - atan_step(it_q);
               end
               else
               begin
                  x_q <= x_q + ys;
                  y_q <= y_q - xs;
                  z_q <= z_q + atan_step(it_q);
               end
               it_q <= it_q + 4'h1;
               if (it_q == `DOU_CORDIC_ITER - 4'h1)
                  state_q <= dou_pkg::CST_SCALE;
            end
            dou_pkg::CST_SCALE:
            begin
               o_x <= px[15+`DOU_DW-1:15];
               o_y <= py[15+`DOU_DW-1:15];
               o_done <= 1'b1;
               o_busy <= 1'b0;
               state_q <= dou_pkg::CST_IDLE;
            end
            default: state_q <= dou_pkg::CST_IDLE;
         endcase
      end
   end

   // Cycles spent busy, for the bounded-rotation check
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         busy_run_q <= 5'h00;
      else if (!o_busy)
         busy_run_q <= 5'h00;
      else if (busy_run_q != 5'h1F)
         busy_run_q <= busy_run_q + 5'h01;
   end

   a_rot_bounded: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_start && !o_busy) |-> ##16 o_done)
      else $error("rotation did not finish in 16 cycles");
   a_rot_busy_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_busy |-> busy_run_q < 5'h0F)
      else $error("rotator busy for more than 15 cycles");
endmodule // dou_rotator

// file: rtl/dou_offset_unit.sv
// Offset stage of the lock-in demodulator: X/Y and magnitude offsets, auto, modify
// How it works
// - A reference phase change rotates the X/Y offset pair by minus that change.
// - X and Y offset enables are one flag, switched together.
// - Auto offset on X captures both X and Y offsets.
// - On/off toggles first channel quantity offset; ignored for noise and aux input.
// - Switching an offset on reuses its last held value, never zero.
// - X/Y offsets precede magnitude; vector indicator for X or magnitude with XY on.
// - Shown magnitude is corrected-XY magnitude plus magnitude offset, plain addition.
// - Magnitude indicator lit whenever the shown magnitude carries the magnitude offset.
// - Log-power offset is signed decibels added straight to the shown value.
// - Auto loads the offset with minus the last value before that offset, so the shown value reads zero.
// - Auto also sets the quantity's offset enable.
// - Auto is ignored for quantities that cannot be offset.
// - Auto on X captures and enables X and Y whatever channel two shows.
// - Modify shows the selected offset on the reference readout, even if disabled.
// - Phase, frequency or aux-output selection restores the reference readout.
// - Offsets are held as percent of full-scale sensitivity.
// - Log-power full scale for percentages is fixed at 200 dBm.
`timescale 1ns/1ns
`include "dou_defs.svh"
module dou_offset_unit
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_sample_valid,
   input wire logic signed [`DOU_DW-1:0] i_x,
   input wire logic signed [`DOU_DW-1:0] i_y,
   input wire logic signed [`DOU_DW-1:0] i_noise,
   input wire logic signed [`DOU_DW-1:0] i_aux1,
   input wire logic [2:0] i_first_channel_sel,
   input wire logic i_cmd_on_off,
   input wire logic i_cmd_auto,
   input wire logic i_cmd_modify,
   input wire logic i_cmd_ref_restore,
   input wire logic i_offset_wr,
   input wire logic [1:0] i_offset_tgt,
   input wire logic signed [`DOU_DW-1:0] i_offset_val,
   input wire logic i_phase_wr,
   input wire logic [`DOU_ANGLE_W-1:0] i_phase,
   output logic signed [`DOU_DW-1:0] o_first_channel_value,
   output logic o_first_channel_valid,
   output logic o_vector_offset_indicator,
   output logic o_magnitude_offset_indicator,
   output logic o_ref_shows_offset,
   output logic signed [`DOU_DW-1:0] o_ref_offset_value,
   output logic o_xy_offset_en,
   output logic o_rv_offset_en,
   output logic o_rdbm_offset_en,
   output logic o_rotate_busy
);
   dou_pkg::dou_qty_t sel;
   logic signed [`DOU_DW-1:0] x_off_q, y_off_q, rv_off_q, rdbm_off_q;
   logic xy_en_q, rv_en_q, rdbm_en_q;
   logic [`DOU_ANGLE_W-1:0] phase_q;
   logic pend_q;
   logic signed [`DOU_DW-1:0] x_raw_q, y_raw_q, mag_last_q, dbm_last_q;
   logic rot_busy, rot_done, rot_start;
   logic signed [`DOU_DW-1:0] rot_x, rot_y;
   logic offsettable, take_sample;
   logic signed [`DOU_DW:0] xc, yc;
   logic [`DOU_DW:0] ax, ay, amax, amin;
   logic [`DOU_DW+1:0] mag_w;
   logic signed [`DOU_DW-1:0] mag_c, dbm_c;
   logic [4:0] msb;
   logic [3:0] frac;
   logic signed [12:0] l2;
   logic signed [31:0] dbm_w;
   logic signed [`DOU_DW-1:0] shown_d;
   logic signed [`DOU_DW-1:0] sel_off;

   assign sel = dou_pkg::dou_qty_t'(i_first_channel_sel);
   // Noise and aux input carry no offset
   assign offsettable = (sel == dou_pkg::QTY_X) || (sel == dou_pkg::QTY_R_VOLT) || (sel == dou_pkg::QTY_LOG_POWER_MAGNITUDE);
   assign rot_start = i_phase_wr && !rot_busy;
   // Samples wait while the rotation is in flight
   assign take_sample = (i_sample_valid || pend_q) && !rot_busy;

   function automatic logic signed [`DOU_DW-1:0] sat(input logic signed [`DOU_DW+1:0] v);
      if (v > (`DOU_DW+2)'(`DOU_SAT_LIMIT))
         sat = `DOU_SAT_LIMIT;
      else if (v < -((`DOU_DW+2)'(`DOU_SAT_LIMIT)))
         sat = -`DOU_SAT_LIMIT;
      else
         sat = v[`DOU_DW-1:0];
   endfunction

   dou_rotator u_rot
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_start(rot_start),
      .i_x(x_off_q),
      .i_y(y_off_q),
      .i_angle(phase_q - i_phase),
      .o_busy(rot_busy),
      .o_done(rot_done),
      .o_x(rot_x),
      .o_y(rot_y)
   );

   // X/Y offsets applied before the magnitude
   always_comb
   begin
      xc = xy_en_q ? (`DOU_DW+1)'(i_x) + (`DOU_DW+1)'(x_off_q) : (`DOU_DW+1)'(i_x);
      yc = xy_en_q ? (`DOU_DW+1)'(i_y) + (`DOU_DW+1)'(y_off_q) : (`DOU_DW+1)'(i_y);
      ax = xc[`DOU_DW] ? (`DOU_DW+1)'(-xc) : (`DOU_DW+1)'(xc);
      ay = yc[`DOU_DW] ? (`DOU_DW+1)'(-yc) : (`DOU_DW+1)'(yc);
      amax = (ax > ay) ? ax : ay;
      amin = (ax > ay) ? ay : ax;
      // Max plus three eighths of min
      mag_w = {1'b0, amax} + (`DOU_DW+2)'(amin >> 2) + (`DOU_DW+2)'(amin >> 3);
      mag_c = sat($signed(mag_w));
   end

   // Log-power in units of 1/50 dB, so 200 dBm spans the full scale
   always_comb
   begin
      msb = 5'h0;
      for (int i = 0; i < `DOU_DW; i++)
         if (mag_c[i])
            msb = 5'(i);
      frac = (msb >= 5'h4) ? 4'(mag_c >> (msb - 5'h4)) : 4'(mag_c << (5'h4 - msb));
      l2 = $signed({1'b0, msb[3:0], 4'h0} + {5'h0, frac}) - $signed({1'b0, `DOU_LOG2_FS_X16});
      dbm_w = (32'(l2) * 32'(`DOU_DB_PER_OCTAVE_X16) * `DOU_DBM_UNITS_PER_DB) >>> 14;
      dbm_c = (mag_c == '0) ? -`DOU_SAT_LIMIT : sat(dbm_w[`DOU_DW+1:0] + (`DOU_DW+2)'(`DOU_DBM_AT_FS));
   end

   // Shown value per selection, magnitude offsets added plainly
   always_comb
   begin
      case (sel)
         dou_pkg::QTY_X: shown_d = sat(xc[`DOU_DW] ? {1'b1, xc} : {1'b0, xc});
         dou_pkg::QTY_R_VOLT: shown_d = sat((`DOU_DW+2)'(mag_c) + (rv_en_q ? (`DOU_DW+2)'(rv_off_q) : '0));
         dou_pkg::QTY_LOG_POWER_MAGNITUDE: shown_d = sat((`DOU_DW+2)'(dbm_c) + (rdbm_en_q ? (`DOU_DW+2)'(rdbm_off_q) : '0));
         dou_pkg::QTY_NOISE: shown_d = i_noise;
         dou_pkg::QTY_AUX1: shown_d = i_aux1;
         default: shown_d = '0;
      endcase
   end

   always_comb
   begin
      case (sel)
         dou_pkg::QTY_X: sel_off = x_off_q;
         dou_pkg::QTY_R_VOLT: sel_off = rv_off_q;
         dou_pkg::QTY_LOG_POWER_MAGNITUDE: sel_off = rdbm_off_q;
         default: sel_off = '0;
      endcase
   end

   // Output sample and capture of the values that auto offset needs
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pend_q <= 1'b0;
         o_first_channel_valid <= 1'b0;
         o_first_channel_value <= '0;
         x_raw_q <= '0;
         y_raw_q <= '0;
         mag_last_q <= '0;
         dbm_last_q <= '0;
      end
      else
      begin
         o_first_channel_valid <= take_sample;
         pend_q <= rot_busy && (pend_q || i_sample_valid);
         if (take_sample)
         begin
            o_first_channel_value <= shown_d;
            x_raw_q <= i_x;
            y_raw_q <= i_y;
            mag_last_q <= mag_c;
            dbm_last_q <= dbm_c;
         end
      end
   end

   // Offset values, kept in percent-of-full-scale units
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         x_off_q <= '0;
         y_off_q <= '0;
         rv_off_q <= '0;
         rdbm_off_q <= '0;
      end
      else if (rot_done)
      begin
         x_off_q <= rot_x;
         y_off_q <= rot_y;
      end
      else if (i_cmd_auto && offsettable)
      begin
         case (sel)
            dou_pkg::QTY_X:
            begin
               x_off_q <= sat(-(`DOU_DW+2)'(x_raw_q));
               y_off_q <= sat(-(`DOU_DW+2)'(y_raw_q));
            end
            dou_pkg::QTY_R_VOLT: rv_off_q <= sat(-(`DOU_DW+2)'(mag_last_q));
            dou_pkg::QTY_LOG_POWER_MAGNITUDE: rdbm_off_q <= sat(-(`DOU_DW+2)'(dbm_last_q));
            default: ;
         endcase
      end
      else if (i_offset_wr)
      begin
         case (dou_pkg::dou_tgt_t'(i_offset_tgt))
            dou_pkg::TGT_X: if (!rot_busy) x_off_q <= sat((`DOU_DW+2)'(i_offset_val));
            dou_pkg::TGT_Y: if (!rot_busy) y_off_q <= sat((`DOU_DW+2)'(i_offset_val));
            dou_pkg::TGT_R_VOLT: rv_off_q <= sat((`DOU_DW+2)'(i_offset_val));
            dou_pkg::TGT_LOG_POWER_MAGNITUDE: rdbm_off_q <= sat((`DOU_DW+2)'(i_offset_val));
            default: ;
         endcase
      end
   end

   // Offset enables; values are left untouched when toggled
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         xy_en_q <= 1'b0;
         rv_en_q <= 1'b0;
         rdbm_en_q <= 1'b0;
      end
      else if (i_cmd_auto && offsettable)
      begin
         case (sel)
            dou_pkg::QTY_X: xy_en_q <= 1'b1;
            dou_pkg::QTY_R_VOLT: rv_en_q <= 1'b1;
            dou_pkg::QTY_LOG_POWER_MAGNITUDE: rdbm_en_q <= 1'b1;
            default: ;
         endcase
      end
      else if (i_cmd_on_off)
      begin
         case (sel)
            dou_pkg::QTY_X: xy_en_q <= !xy_en_q;
            dou_pkg::QTY_R_VOLT: rv_en_q <= !rv_en_q;
            dou_pkg::QTY_LOG_POWER_MAGNITUDE: rdbm_en_q <= !rdbm_en_q;
            default: ;
         endcase
      end
   end

   // Reference phase tracking
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         phase_q <= '0;
      else if (rot_start)
         phase_q <= i_phase;
   end

   // Reference readout and indicators
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_ref_shows_offset <= 1'b0;
         o_ref_offset_value <= '0;
         o_vector_offset_indicator <= 1'b0;
         o_magnitude_offset_indicator <= 1'b0;
         o_xy_offset_en <= 1'b0;
         o_rv_offset_en <= 1'b0;
         o_rdbm_offset_en <= 1'b0;
         o_rotate_busy <= 1'b0;
      end
      else
      begin
         if (i_cmd_ref_restore)
            o_ref_shows_offset <= 1'b0;
         else if (i_cmd_modify && offsettable)
            o_ref_shows_offset <= 1'b1;
         o_ref_offset_value <= sel_off;
         o_vector_offset_indicator <= xy_en_q && offsettable;
         o_magnitude_offset_indicator <= (sel == dou_pkg::QTY_R_VOLT && rv_en_q)
            || (sel == dou_pkg::QTY_LOG_POWER_MAGNITUDE && rdbm_en_q);
         o_xy_offset_en <= xy_en_q;
         o_rv_offset_en <= rv_en_q;
         o_rdbm_offset_en <= rdbm_en_q;
         o_rotate_busy <= rot_busy;
      end
   end

   sequence s_auto_x;
      i_cmd_auto && sel == dou_pkg::QTY_X && !rot_done;
   endsequence
   sequence s_both_zeroed;
      xy_en_q && x_off_q == sat(-(`DOU_DW+2)'($past(x_raw_q))) && y_off_q == sat(-(`DOU_DW+2)'($past(y_raw_q)));
   endsequence

   a_auto_xy_both: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_auto_x |=> s_both_zeroed)
      else $error("auto on X did not capture both X and Y");
   a_onoff_joint: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd_on_off && !i_cmd_auto && sel == dou_pkg::QTY_X) |=> xy_en_q != $past(xy_en_q))
      else $error("on/off did not toggle the X/Y enable");
   a_onoff_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd_on_off && !offsettable) |=> $stable(xy_en_q) && $stable(rv_en_q) && $stable(rdbm_en_q))
      else $error("on/off changed an enable for a non-offsettable quantity");
   a_auto_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd_auto && !offsettable && !i_offset_wr && !rot_done) |=> $stable(rv_off_q) && $stable(x_off_q))
      else $error("auto changed offsets for a non-offsettable quantity");
   a_enable_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd_on_off && !i_cmd_auto && !i_offset_wr && sel == dou_pkg::QTY_R_VOLT) |=> $stable(rv_off_q))
      else $error("switching the offset changed its value");
   a_auto_enables: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd_auto && sel == dou_pkg::QTY_R_VOLT) |=> rv_en_q ##1 o_rv_offset_en)
      else $error("auto did not enable the magnitude offset");
   a_modify_shows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_cmd_modify && offsettable && !i_cmd_ref_restore) |=> o_ref_shows_offset)
      else $error("modify did not show the offset");
   a_ref_restore: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_cmd_ref_restore |=> !o_ref_shows_offset)
      else $error("reference readout not restored");
   a_rot_apply: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rot_done |=> x_off_q == $past(rot_x) && y_off_q == $past(rot_y))
      else $error("rotated offsets not stored");
   a_mag_indicator: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (sel == dou_pkg::QTY_R_VOLT && rv_en_q) ##1 (sel == dou_pkg::QTY_R_VOLT) |-> o_magnitude_offset_indicator)
      else $error("magnitude offset indicator not lit");
   a_vec_indicator: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!xy_en_q) |=> !o_vector_offset_indicator)
      else $error("vector offset indicator lit with X/Y offsets off");
   a_sample_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rot_busy |=> !o_first_channel_valid)
      else $error("sample used offsets during rotation");
endmodule // dou_offset_unit

// file: verif/dou_panel_model.sv
// Key handler and remote controller model driving the offset unit
`timescale 1ns/1ns
`include "dou_defs.svh"
module dou_panel_model
(
   input wire logic i_clk,
   input wire logic i_first_channel_valid,
   input wire logic signed [`DOU_DW-1:0] i_first_channel_value,
   output logic o_sample_valid,
   output logic signed [`DOU_DW-1:0] o_x,
   output logic signed [`DOU_DW-1:0] o_y,
   output logic signed [`DOU_DW-1:0] o_noise,
   output logic signed [`DOU_DW-1:0] o_aux1,
   output logic [2:0] o_first_channel_sel,
   output logic o_cmd_on_off,
   output logic o_cmd_auto,
   output logic o_cmd_modify,
   output logic o_cmd_ref_restore,
   output logic o_offset_wr,
   output logic [1:0] o_offset_tgt,
   output logic signed [`DOU_DW-1:0] o_offset_val,
   output logic o_phase_wr,
   output logic [`DOU_ANGLE_W-1:0] o_phase
);
   initial
   begin
      {o_sample_valid, o_cmd_on_off, o_cmd_auto, o_cmd_modify, o_cmd_ref_restore, o_offset_wr, o_phase_wr} = 7'h00;
      {o_x, o_y, o_noise, o_aux1, o_offset_val, o_phase} = 96'h0;
      o_first_channel_sel = 3'h0;
      o_offset_tgt = 2'h0;
   end

   // Pulse order: on/off, auto, modify, restore
   task automatic cmd(input logic [3:0] m);
      @(posedge i_clk);
      #1;
      {o_cmd_on_off, o_cmd_auto, o_cmd_modify, o_cmd_ref_restore} = m;
      @(posedge i_clk);
      #1;
      {o_cmd_on_off, o_cmd_auto, o_cmd_modify, o_cmd_ref_restore} = 4'h0;
      repeat (2) @(posedge i_clk);
   endtask

   // Offsets are full-scale relative: rewrite them after a sensitivity change
   task automatic wr_off(input logic [1:0] tgt, input logic signed [15:0] val);
      @(posedge i_clk);
      #1;
      o_offset_wr = 1'b1;
      o_offset_tgt = tgt;
      o_offset_val = val;
      @(posedge i_clk);
      #1;
      o_offset_wr = 1'b0;
      o_offset_val = ~val;
      repeat (2) @(posedge i_clk);
   endtask

   task automatic set_phase(input logic [15:0] p);
      @(posedge i_clk);
      #1;
      o_phase_wr = 1'b1;
      o_phase = p;
      @(posedge i_clk);
      #1;
      o_phase_wr = 1'b0;
   endtask

   task automatic set_sel(input logic [2:0] s);
      @(posedge i_clk);
      #1;
      o_first_channel_sel = s;
      repeat (2) @(posedge i_clk);
   endtask

   // Sample data held until the answer shows, then driven stale
   task automatic sample(input logic signed [15:0] x, y, n, output logic signed [15:0] v, output bit to);
      @(posedge i_clk);
      #1;
      {o_x, o_y, o_noise, o_aux1, o_sample_valid} = {x, y, n, ~n, 1'b1};
      @(posedge i_clk);
      #1;
      o_sample_valid = 1'b0;
      to = 1'b1;
      for (int k = 0; k < 40 && to; k++)
      begin
         if (i_first_channel_valid === 1'b1)
         begin
            v = i_first_channel_value;
            to = 1'b0;
         end
         else
         begin
            @(posedge i_clk);
            #1;
         end
      end
      {o_x, o_y, o_noise, o_aux1} = {~x, ~y, ~n, n};
   endtask
endmodule // dou_panel_model

// file: verif/demod_offset_unit_test.sv
// Self-checking bench for the demodulator offset unit
`timescale 1ns/1ns
`include "dou_defs.svh"
module demod_offset_unit_test;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   wire logic sv, cv, c_oo, c_au, c_md, c_rs, owr, pwr, vind, mind, rso, xen, rven, rden, busy;
   wire logic signed [15:0] x, y, nz, a1, oval, cval, rval;
   wire logic [2:0] sel;
   wire logic [1:0] tgt;
   wire logic [15:0] ph;
   int bad_count = 0;
   int num_checks = 0;

   always #4 i_clk = ~i_clk;

   dou_offset_unit uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sample_valid(sv), .i_x(x), .i_y(y),
      .i_noise(nz), .i_aux1(a1), .i_first_channel_sel(sel), .i_cmd_on_off(c_oo), .i_cmd_auto(c_au),
      .i_cmd_modify(c_md), .i_cmd_ref_restore(c_rs), .i_offset_wr(owr), .i_offset_tgt(tgt), .i_offset_val(oval),
      .i_phase_wr(pwr), .i_phase(ph), .o_first_channel_value(cval), .o_first_channel_valid(cv),
      .o_vector_offset_indicator(vind), .o_magnitude_offset_indicator(mind), .o_ref_shows_offset(rso),
      .o_ref_offset_value(rval), .o_xy_offset_en(xen), .o_rv_offset_en(rven), .o_rdbm_offset_en(rden),
      .o_rotate_busy(busy));

   dou_panel_model host (.i_clk(i_clk), .i_first_channel_valid(cv), .i_first_channel_value(cval),
      .o_sample_valid(sv), .o_x(x), .o_y(y), .o_noise(nz), .o_aux1(a1), .o_first_channel_sel(sel),
      .o_cmd_on_off(c_oo), .o_cmd_auto(c_au), .o_cmd_modify(c_md), .o_cmd_ref_restore(c_rs),
      .o_offset_wr(owr), .o_offset_tgt(tgt), .o_offset_val(oval), .o_phase_wr(pwr), .o_phase(ph));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic flag(input string what, input logic seen, input logic exp);
      check(what, {15'h0, seen}, {15'h0, exp});
   endtask

   // Close match for values that pass through the rotator or the log-power path
   task automatic near(input string what, input logic signed [15:0] seen, input logic signed [15:0] exp);
      logic ok;
      ok = !$isunknown(seen) && (seen - exp < 16'sh0009) && (exp - seen < 16'sh0009);
      if (!ok)
         check(what, seen, exp);
      else
         num_checks++;
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic smp(input logic signed [15:0] sx, sy, sn, output logic signed [15:0] v);
      bit to;
      host.sample(sx, sy, sn, v, to);
      if (to)
      begin
         bad_count++;
         $display("[ERR] sample answer expected 1 seen 0");
         give_verdict();
      end
   endtask

   initial
   begin
      logic signed [15:0] v;
      int n;
      repeat (4) @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      flag("xy enable at reset", xen, 1'b0);
      // Offsets toggle together and reuse the held value
      host.wr_off(2'h0, 16'sh0064);
      smp(16'sh01F4, 16'sh0000, 16'sh0000, v);
      check("x offset off", v, 16'h01F4);
      flag("vector ind off", vind, 1'b0);
      host.cmd(4'h8);
      flag("xy enable on", xen, 1'b1);
      smp(16'sh01F4, 16'sh0000, 16'sh0000, v);
      check("x with offset", v, 16'h0258);
      flag("vector ind on", vind, 1'b1);
      host.cmd(4'h2);
      flag("modify shows", rso, 1'b1);
      check("modify value", rval, 16'h0064);
      host.cmd(4'h1);
      flag("restore", rso, 1'b0);
      host.cmd(4'h8);
      flag("xy enable toggled off", xen, 1'b0);
      host.cmd(4'h2);
      check("modify while off", rval, 16'h0064);
      flag("modify shows while off", rso, 1'b1);
      host.cmd(4'h1);
      $display("test toggle done");
      // Noise and aux input cannot be offset
      for (int s = 3; s < 5; s++)
      begin
         host.set_sel(3'(s));
         host.cmd(4'h8);
         host.cmd(4'h4);
         flag("no enable", xen | rven | rden, 1'b0);
         smp(16'sh01F4, 16'sh0000, 16'sh004D, v);
         check("passthrough", v, (s == 3) ? 16'h004D : 16'hFFB2);
      end
      $display("test fixed quantities done");
      // Auto on X captures both X and Y
      host.set_sel(3'h0);
      smp(16'sh012C, 16'sh0190, 16'sh0000, v);
      host.cmd(4'h4);
      flag("auto enables xy", xen, 1'b1);
      smp(16'sh012C, 16'sh0190, 16'sh0000, v);
      check("auto x zero", v, 16'h0000);
      host.set_sel(3'h1);
      smp(16'sh012C, 16'sh0190, 16'sh0000, v);
      check("auto y captured", v, 16'h0000);
      $display("test auto done");
      // Magnitude offset in volts
      host.wr_off(2'h2, 16'sh0032);
      flag("mag ind off", mind, 1'b0);
      host.cmd(4'h8);
      flag("rv enable", rven, 1'b1);
      smp(16'sh0514, 16'sh0190, 16'sh0000, v);
      check("magnitude plus offset", v, 16'h041A);
      flag("mag ind on", mind, 1'b1);
      flag("vector ind mag", vind, 1'b1);
      smp(16'sh012C, 16'sh0578, 16'sh0000, v);
      check("magnitude y path", v, 16'h041A);
      // Log-power auto reads zero
      host.set_sel(3'h2);
      smp(16'sh212C, 16'sh0190, 16'sh0000, v);
      near("dbm reading", v, -16'sh0057);
      host.cmd(4'h4);
      flag("dbm enable", rden, 1'b1);
      smp(16'sh212C, 16'sh0190, 16'sh0000, v);
      check("dbm auto zero", v, 16'h0000);
      flag("mag ind dbm", mind, 1'b1);
      $display("test magnitude done");
      // Quarter-turn phase change rotates the X/Y offsets
      host.set_sel(3'h0);
      host.set_phase(16'h4000);
      n = 0;
      while (busy !== 1'b1 && n < 5)
      begin
         @(posedge i_clk) #1;
         n++;
      end
      flag("rotation starts", busy, 1'b1);
      n = 0;
      while (busy !== 1'b0 && n < 60)
      begin
         @(posedge i_clk) #1;
         n++;
      end
      flag("rotation ends", busy, 1'b0);
      repeat (2) @(posedge i_clk);
      #1;
      near("rotated x", rval, -16'sh0190);
      host.set_sel(3'h1);
      smp(16'sh0190, -16'sh012C, 16'sh0000, v);
      near("rotated pair cancels", v, 16'sh0032);
      $display("test rotation done");
      give_verdict();
   end
endmodule // demod_offset_unit_test
